// >>> twpsi_defs.svh
/*
 constants for the two-wire pot slave interface: field positions, reset values, timing.
 assumes inclusion by bare name, before any use.
*/
`ifndef TWPSI_DEFS_SVH
`define TWPSI_DEFS_SVH
// ----------------------------------------
// command byte fields
// ----------------------------------------
`define TWPSI_OP_POS 4
`define TWPSI_RS_POS 2
`define TWPSI_PS_POS 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define TWPSI_DR_RST 6'h00
// arbitrary device type code
`define TWPSI_DEV_TYPE 4'hA
// ----------------------------------------
// timing
// ----------------------------------------
`define TWPSI_CLK_NS 25
`define TWPSI_TWR_NS 5000000
`endif

// >>> twpsi_pkg.sv
/*
 types for the two-wire pot slave interface.
 assumes nothing of its surroundings.
*/
`default_nettype none
package twpsi_pkg;
	typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_CMD = 3'h3, ST_RX = 3'h2,
		ST_TX = 3'h6, ST_INC = 3'h7, ST_WSTP = 3'h5} twpsi_st_e;
	typedef enum logic [3:0] {OP_GDW = 4'h1, OP_INC = 4'h2, OP_GWD = 4'h8, OP_RDW = 4'h9,
		OP_WRW = 4'hA, OP_RDD = 4'hB, OP_WRD = 4'hC, OP_XDW = 4'hD, OP_XWD = 4'hE} twpsi_op_e;
	typedef logic [17:0] twpsi_tmr_t;
	typedef struct packed {
		logic [2:0]            scl_r;
		logic [2:0]            sda_r;
		logic [1:0]            wp_r;
		logic [1:0][3:0]       as_r;
		twpsi_st_e             st;
		logic [3:0]            cnt;
		logic [7:0]            sr;
		twpsi_op_e             op;
		logic [1:0]            rsel;
		logic [1:0]            psel;
		logic                  drv;
		logic                  nv_pend;
		logic                  busy;
		twpsi_tmr_t            tmr;
		logic                  recall;
		logic [3:0][5:0]       wiper;
		logic [3:0][3:0][5:0]  dr;
		logic [255:0]          taps;
	} twpsi_state_s;
endpackage
`default_nettype wire

// >>> twpsi_top.sv
/*
 two-wire slave interface of a quad digital pot: wipers, data registers, tap decode.
 assumes scl/sda/pins asynchronous to REF_CLK_IN; sda wire resolved outside from SDA_OE_OUT.
*/
//
// Contract
// - low four address bits come from the address select pins.
// - data line is open drain: pull low or release.
// - data line changes only while clock is low.
// - falling data with clock high is a start.
// - bus activity ignored until a start is seen.
// - rising data with clock high is a stop.
// - transmitter releases after eight bits; receiver pulls low on ninth clock.
// - acknowledge address, command byte, and following data byte.
// - acknowledge address only when all four select bits match.
// - each 6-bit wiper turns on exactly one of 64 taps.
// - four wipers, each written directly or loaded from its data registers.
// - host reads and writes every wiper and data register.
// - write protect low blocks every nonvolatile data register write.
// - command byte: opcode high four, register select two, pot select two.
// - no address acknowledge while a nonvolatile write cycle runs.
// - at power-up each wiper loads from its default data register.
`timescale 1ns/100ps
`default_nettype none
`include "twpsi_defs.svh"
module twpsi_top #(
	parameter logic [3:0] DEV_TYPE = `TWPSI_DEV_TYPE,
	parameter logic [5:0] DR_INIT  = `TWPSI_DR_RST,
	parameter int unsigned TWR_CYC = (`TWPSI_TWR_NS + `TWPSI_CLK_NS - 1) / `TWPSI_CLK_NS
) (
	// clock and reset
	input  wire logic         REF_CLK_IN,
	input  wire logic         SYS_RST_IN,
	// serial bus
	input  wire logic         SCL_IN,
	input  wire logic         SDA_IN,
	output logic              SDA_OUT,
	output logic              SDA_OE_OUT,
	// straps
	input  wire logic [3:0]   ADDR_SEL_IN,
	input  wire logic         WP_N_IN,
	// pot side
	output logic [255:0]      TAP_SEL_OUT,
	output logic              NV_BUSY_OUT
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [63:0] tap_dec(input logic [5:0] w);
		tap_dec = 64'h0000_0000_0000_0001 << w;
	endfunction

	function automatic twpsi_pkg::twpsi_state_s rst_val(input logic [5:0] d);
		twpsi_pkg::twpsi_state_s s;
		s = '0;
		s.scl_r = 3'h7;
		s.sda_r = 3'h7;
		s.wp_r = 2'h3;
		s.recall = 1'b1;
		s.dr = {16{d}};
		s.taps = {4{64'h0000_0000_0000_0001}};
		rst_val = s;
	endfunction

	localparam twpsi_pkg::twpsi_state_s RST_S = rst_val(DR_INIT);

	twpsi_pkg::twpsi_state_s q;
	twpsi_pkg::twpsi_state_s n;
	logic                    rise_ev;
	logic                    fall_ev;
	logic                    start_ev;
	logic                    stop_ev;
	logic                    sda_s;

	// ----------------------------------------
	// bus condition detection
	// ----------------------------------------
	assign sda_s = q.sda_r[1];
	assign rise_ev = q.scl_r[1] & ~q.scl_r[2];
	assign fall_ev = ~q.scl_r[1] & q.scl_r[2];
	assign start_ev = q.scl_r[1] & q.scl_r[2] & q.sda_r[2] & ~q.sda_r[1];
	assign stop_ev = q.scl_r[1] & q.scl_r[2] & ~q.sda_r[2] & q.sda_r[1];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		twpsi_pkg::twpsi_op_e op;
		logic [1:0]           rs;
		logic [1:0]           ps;
		op = twpsi_pkg::twpsi_op_e'(q.sr[`TWPSI_OP_POS +: 4]);
		rs = q.sr[`TWPSI_RS_POS +: 2];
		ps = q.sr[`TWPSI_PS_POS +: 2];
		n = q;
		n.scl_r = {q.scl_r[1:0], SCL_IN};
		n.sda_r = {q.sda_r[1:0], SDA_IN};
		n.wp_r = {q.wp_r[0], WP_N_IN};
		n.as_r = {q.as_r[0], ADDR_SEL_IN};
		if (q.busy)
		begin
			n.tmr = q.tmr - 18'h00001;
			if (q.tmr == 18'h00001)
				n.busy = 1'b0;
		end
		// power-up recall of the default register
		if (q.recall)
		begin
			n.recall = 1'b0;
			for (int p = 0; p < 4; p++)
				n.wiper[p] = q.dr[p][0];
		end
		if (start_ev)
		begin
			n.st = twpsi_pkg::ST_ADDR;
			// one below zero: the clock fall right after a start precedes the first bit
			n.cnt = 4'hF;
			n.drv = 1'b0;
		end
		else if (stop_ev)
		begin
			n.st = twpsi_pkg::ST_IDLE;
			n.drv = 1'b0;
			if (q.nv_pend)
			begin
				n.nv_pend = 1'b0;
				n.busy = 1'b1;
				n.tmr = twpsi_pkg::twpsi_tmr_t'(TWR_CYC);
			end
		end
		else
		begin
			case (q.st)
				// idle, and mismatched or finished frames, wait for a start
				twpsi_pkg::ST_IDLE, twpsi_pkg::ST_WSTP:
					n.drv = 1'b0;
				twpsi_pkg::ST_INC:
					if (rise_ev)
					begin
						if (sda_s && q.wiper[q.psel] != 6'h3F)
							n.wiper[q.psel] = q.wiper[q.psel] + 6'h01;
						else if (!sda_s && q.wiper[q.psel] != 6'h00)
							n.wiper[q.psel] = q.wiper[q.psel] - 6'h01;
					end
				default:
				begin
					if (rise_ev && q.st != twpsi_pkg::ST_TX)
						n.sr = {q.sr[6:0], sda_s};
					if (fall_ev)
					begin
						case (q.cnt)
							4'h7:
							begin
								n.cnt = 4'h8;
								// transmitter releases for the ninth clock
								n.drv = 1'b0;
								case (q.st)
									twpsi_pkg::ST_ADDR:
										// match on type, pins and idle
										if (q.sr == {DEV_TYPE, q.as_r[1]} && !q.busy)
											n.drv = 1'b1;
										else
											n.st = twpsi_pkg::ST_WSTP;
									twpsi_pkg::ST_CMD:
									begin
										n.op = op;
										n.rsel = rs;
										n.psel = ps;
										n.drv = 1'b1;
										case (op)
											twpsi_pkg::OP_XDW:
												n.wiper[ps] = q.dr[ps][rs];
											twpsi_pkg::OP_GDW:
												for (int p = 0; p < 4; p++)
													n.wiper[p] = q.dr[p][rs];
											twpsi_pkg::OP_XWD:
												if (q.wp_r[1])
												begin
													n.dr[ps][rs] = q.wiper[ps];
													n.nv_pend = 1'b1;
												end
											twpsi_pkg::OP_GWD:
												if (q.wp_r[1])
												begin
													for (int p = 0; p < 4; p++)
														n.dr[p][rs] = q.wiper[p];
													n.nv_pend = 1'b1;
												end
											twpsi_pkg::OP_RDW, twpsi_pkg::OP_WRW, twpsi_pkg::OP_RDD,
											twpsi_pkg::OP_WRD, twpsi_pkg::OP_INC:
												n.drv = 1'b1;
											default:
											begin
												n.drv = 1'b0;
												n.st = twpsi_pkg::ST_WSTP;
											end
										endcase
									end
									twpsi_pkg::ST_RX:
									begin
										n.drv = 1'b1;
										if (q.op == twpsi_pkg::OP_WRW)
											n.wiper[q.psel] = q.sr[5:0];
										else if (q.wp_r[1])
										begin
											n.dr[q.psel][q.rsel] = q.sr[5:0];
											n.nv_pend = 1'b1;
										end
									end
									default:
										n.drv = 1'b0;
								endcase
							end
							4'h8:
							begin
								n.cnt = 4'h0;
								n.drv = 1'b0;
								case (q.st)
									twpsi_pkg::ST_ADDR:
										n.st = twpsi_pkg::ST_CMD;
									twpsi_pkg::ST_CMD:
										case (q.op)
											twpsi_pkg::OP_WRW, twpsi_pkg::OP_WRD:
												n.st = twpsi_pkg::ST_RX;
											twpsi_pkg::OP_RDW, twpsi_pkg::OP_RDD:
											begin
												// read back wiper or data register
												n.st = twpsi_pkg::ST_TX;
												n.sr = {2'b00, q.op == twpsi_pkg::OP_RDW ?
													q.wiper[q.psel] : q.dr[q.psel][q.rsel]};
												n.drv = 1'b1;
											end
											twpsi_pkg::OP_INC:
												n.st = twpsi_pkg::ST_INC;
											default:
												n.st = twpsi_pkg::ST_WSTP;
										endcase
									default:
										n.st = twpsi_pkg::ST_WSTP;
								endcase
							end
							default:
							begin
								n.cnt = q.cnt + 4'h1;
								// shift out on the falling clock
								if (q.st == twpsi_pkg::ST_TX)
								begin
									n.sr = {q.sr[6:0], 1'b0};
									n.drv = ~q.sr[6];
								end
							end
						endcase
					end
				end
			endcase
		end
		for (int p = 0; p < 4; p++)
			n.taps[p * 64 +: 64] = tap_dec(n.wiper[p]);
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			q <= RST_S;
		else
			q <= n;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = q.drv;
	assign TAP_SEL_OUT = q.taps;
	assign NV_BUSY_OUT = q.busy;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	start_addr_a: assert property (start_ev |=> q.st == twpsi_pkg::ST_ADDR && q.cnt == 4'hF && !q.drv)
		else $error("start not taken");
	idle_hold_a: assert property (q.st == twpsi_pkg::ST_IDLE && !start_ev |=> q.st == twpsi_pkg::ST_IDLE)
		else $error("left idle without start");
	stop_idle_a: assert property (stop_ev |=> q.st == twpsi_pkg::ST_IDLE && !q.drv)
		else $error("stop not taken");
	oe_scl_low_a: assert property ($changed(q.drv) |-> !q.scl_r[1])
		else $error("data changed with clock high");
	od_state_a: assert property (q.drv |-> q.st inside {twpsi_pkg::ST_ADDR, twpsi_pkg::ST_CMD,
		twpsi_pkg::ST_RX, twpsi_pkg::ST_TX})
		else $error("pulling low outside a byte");
	addr_miss_a: assert property (fall_ev && q.st == twpsi_pkg::ST_ADDR && q.cnt == 4'h7 &&
		(q.sr != {DEV_TYPE, q.as_r[1]} || q.busy) |=> !q.drv && q.st == twpsi_pkg::ST_WSTP)
		else $error("acked bad address or while busy");
	addr_ack_a: assert property (fall_ev && q.st == twpsi_pkg::ST_ADDR && q.cnt == 4'h7 &&
		q.sr == {DEV_TYPE, q.as_r[1]} && !q.busy |=> q.drv && q.cnt == 4'h8)
		else $error("matching address not acked");
	ack_release_a: assert property ($rose(q.drv) && q.cnt == 4'h8 |-> ##[1:1000] !q.drv)
		else $error("ack never released");
	wp_block_a: assert property (!q.wp_r[1] |=> $stable(q.dr))
		else $error("data register written under protect");
	recall_a: assert property (q.recall |=> q.wiper[0] == $past(q.dr[0][0]) &&
		q.wiper[3] == $past(q.dr[3][0]))
		else $error("wiper not recalled");
	for (genvar g = 0; g < 4; g++)
	begin : g_oh
		tap_onehot_a: assert property ($onehot(q.taps[g * 64 +: 64]))
			else $error("tap select not one-hot");
	end

	cmd_ack_c: cover property (q.st == twpsi_pkg::ST_CMD && q.cnt == 4'h8 && q.drv);
	read_c: cover property (q.st == twpsi_pkg::ST_TX && q.cnt == 4'h7);
	inc_c: cover property (q.st == twpsi_pkg::ST_INC ##1 $changed(q.wiper));
	busy_c: cover property ($rose(q.busy));
endmodule // twpsi_top
`default_nettype wire

// >>> twpsi_host_model.sv
/*
 two-wire bus master model: drives the bus clock, pulls the data line low or releases it.
 assumes the data line is resolved outside with a pull-up; all changes land on clk_in falls.
*/
`timescale 1ns/100ps
`default_nettype none
module twpsi_host_model (
	// clock
	input  wire logic clk_in,
	// bus
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_oe_out
);
	// ----------------------------------------
	// bus primitives
	// ----------------------------------------
	initial
	begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	task automatic hp(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic bit_io(input logic b, output logic s);
		scl_out = 1'b0;
		hp(1);
		sda_oe_out = !b;
		hp(3);
		scl_out = 1'b1;
		hp(4);
		s = sda_in;
	endtask
	task automatic start;
		scl_out = 1'b0;
		hp(1);
		sda_oe_out = 1'b0;
		hp(3);
		scl_out = 1'b1;
		hp(4);
		sda_oe_out = 1'b1;
		hp(4);
	endtask
	task automatic stop;
		scl_out = 1'b0;
		hp(1);
		sda_oe_out = 1'b1;
		hp(3);
		scl_out = 1'b1;
		hp(4);
		sda_oe_out = 1'b0;
		hp(4);
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask
endmodule // twpsi_host_model
`default_nettype wire

// >>> testbench.sv
/*
 self-checking bench for the two-wire pot slave interface.
 assumes twpsi_top and twpsi_host_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// arbitrary type code
	localparam logic [3:0] DEV = 4'h6;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             wp_n = 1'b1;
	logic [3:0]       sel = 4'h9;
	logic             scl, m_oe, d_oe, d_out, busy;
	logic [255:0]     taps;
	logic [5:0]       wexp [4];
	int               fail_count = 0;
	int               cmp_count = 0;
	int               cyc = 0;
	wire logic        sda = !(m_oe || d_oe);
	always #12.5 clk = !clk;
	twpsi_top #(.DEV_TYPE(DEV), .DR_INIT(6'h15), .TWR_CYC(400)) DUT (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(d_out), .SDA_OE_OUT(d_oe), .ADDR_SEL_IN(sel), .WP_N_IN(wp_n),
		.TAP_SEL_OUT(taps), .NV_BUSY_OUT(busy));
	twpsi_host_model host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [255:0] e, input logic [255:0] g);
		cmp_count++;
		if (e !== g)
		begin
			fail_count++;
			$display("ERROR %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [255:0] tmap;
		logic [255:0] t;
		t = '0;
		for (int i = 0; i < 4; i++)
			t[i*64 + int'(wexp[i])] = 1'b1;
		return t;
	endfunction
	// address, then nb more bytes; a holds the acks seen
	task automatic frame(input logic [7:0] ad, input logic [7:0] c, input int nb, input logic [7:0] d,
		output logic [7:0] q, output logic [2:0] a);
		logic [7:0] x;
		a = 3'h0;
		q = 8'h00;
		host.start();
		host.xfer(ad, x, a[2]);
		if (nb > 0) host.xfer(c, x, a[1]);
		if (nb > 1) host.xfer(d, q, a[0]);
		host.stop();
	endtask
	task automatic wr(input logic [3:0] op, input logic [1:0] r, input logic [1:0] p, input logic [7:0] d);
		logic [7:0] q;
		logic [2:0] a;
		frame({DEV, sel}, {op, r, p}, 2, d, q, a);
		chk("wr_acks", 3'h7, a);
	endtask
	task automatic rd(input logic [3:0] op, input logic [1:0] r, input logic [1:0] p, input logic [5:0] e);
		logic [7:0] q;
		logic [2:0] a;
		frame({DEV, sel}, {op, r, p}, 2, 8'hFF, q, a);
		chk("rd_acks", 3'h6, a);
		chk("rd_data", {2'h0, e}, q);
	endtask
	task automatic xc(input logic [3:0] op, input logic [1:0] r, input logic [1:0] p);
		logic [7:0] q;
		logic [2:0] a;
		frame({DEV, sel}, {op, r, p}, 1, 8'h00, q, a);
		chk("xc_acks", 3'h6, a);
	endtask
	task automatic wait_nv;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
		chk("busy_end", 1'b0, busy);
	endtask
	// the start before stop absorbs one extra step at the top end
	task automatic incdec(input logic [1:0] p, input logic up);
		logic [7:0] x;
		logic [2:0] a;
		host.start();
		host.xfer({DEV, sel}, x, a[2]);
		host.xfer({4'h2, 2'h0, p}, x, a[1]);
		repeat (4) host.bit_io(up, a[0]);
		if (up) host.start();
		host.stop();
		chk("inc_acks", 2'h3, a[2:1]);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		logic [7:0] q;
		logic [2:0] a;
		logic [5:0] sv [4];
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		wexp = '{default: 6'h15};
		chk("taps_rst", tmap(), taps);
		chk("sda_val", 1'b0, d_out);
		for (int p = 0; p < 4; p++)
		begin
			wexp[p] = 6'(p * 13 + 5);
			wr(4'hA, 2'h0, 2'(p), {2'h3, wexp[p]});
			rd(4'h9, 2'h0, 2'(p), wexp[p]);
		end
		chk("taps_wr", tmap(), taps);
		frame({DEV, 4'h1}, 8'hA0, 2, 8'h3F, q, a);
		chk("nack_sel", 3'h0, a);
		frame({~DEV, sel}, 8'hA0, 2, 8'h3F, q, a);
		chk("nack_type", 3'h0, a);
		frame({DEV, sel}, 8'h30, 2, 8'h00, q, a);
		chk("nack_op", 3'h4, a);
		chk("taps_kept", tmap(), taps);
		sel = 4'h3;
		rd(4'h9, 2'h0, 2'h0, wexp[0]);
		sel = 4'h9;
		wr(4'hC, 2'h2, 2'h1, 8'h2A);
		chk("busy", 1'b1, busy);
		frame({DEV, sel}, 8'h00, 0, 8'h00, q, a);
		chk("poll_nack", 3'h0, a);
		wait_nv();
		rd(4'hB, 2'h2, 2'h1, 6'h2A);
		wp_n = 1'b0;
		wr(4'hC, 2'h2, 2'h1, 8'h15);
		chk("busy_wp", 1'b0, busy);
		rd(4'hB, 2'h2, 2'h1, 6'h2A);
		wp_n = 1'b1;
		xc(4'hD, 2'h2, 2'h1);
		wexp[1] = 6'h2A;
		chk("taps_xfr", tmap(), taps);
		xc(4'hE, 2'h1, 2'h0);
		wait_nv();
		rd(4'hB, 2'h1, 2'h0, wexp[0]);
		xc(4'h8, 2'h3, 2'h0);
		wait_nv();
		sv = wexp;
		wr(4'hA, 2'h0, 2'h2, 8'h00);
		xc(4'h1, 2'h3, 2'h0);
		wexp = sv;
		chk("taps_glob", tmap(), taps);
		wr(4'hA, 2'h0, 2'h3, 8'h3D);
		incdec(2'h3, 1'b1);
		wexp[3] = 6'h3F;
		chk("taps_up", tmap(), taps);
		wr(4'hA, 2'h0, 2'h3, 8'h02);
		incdec(2'h3, 1'b0);
		wexp[3] = 6'h00;
		chk("taps_dn", tmap(), taps);
		tally_and_finish();
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
endmodule // testbench
`default_nettype wire
